/* File: src/incr_exec_pkg.sv */
package incr_exec_pkg;

  localparam int InstrWidth = 14;
  localparam int DataWidth = 8;
  localparam int AddrWidth = 7;

  // Opcode fields of the 14-bit instruction word.
  localparam logic [5:0] OpIncSkip = 6'h0f;
  localparam logic [5:0] OpIncFile = 6'h0a;
  localparam logic [5:0] OpOrLitHi = 6'h38;
  localparam int OpMsb = 13;
  localparam int OpLsb = 8;
  localparam int DestBit = 7;
  localparam int AddrMsb = 6;
  localparam int LitMsb = 7;

  // Reset values.
  localparam logic [7:0] AccReset = 8'h00;
  localparam logic ZeroReset = 1'b0;

  typedef enum logic [1:0] {
    StExec = 2'b01,
    StSkip = 2'b10
  } exec_state_t;

endpackage : incr_exec_pkg

/* File: src/incr_alu.sv */
`timescale 1ns/1ps
`default_nettype none
// Registered incrementer: result and its zero indication one cycle later.
module incr_alu
  import incr_exec_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Operand and result.
  input wire logic [DataWidth-1:0] operand,
  output logic [DataWidth-1:0] sum,
  output logic sumZero
);

  typedef struct packed {
    logic [DataWidth-1:0] sum;
    logic zero;
  } alu_state_t;

  alu_state_t st_r;
  alu_state_t st_nxt;

  always_comb begin
    st_nxt.sum = operand + 8'h01;
    st_nxt.zero = (st_nxt.sum == 8'h00);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sum = st_r.sum;
  assign sumZero = st_r.zero;

endmodule // incr_alu
`default_nettype wire

/* File: src/incr_skip_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Increment-skip: add one, keep status flags
// - Destination bit 0 sends result to accumulator
// - Destination bit 1 writes result to file
// - Increment-skip zero result discards next instruction, two cycles
// - Plain increment updates zero flag, one cycle
// - OR literal into accumulator, update zero
module incr_skip_exec
  import incr_exec_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Instruction issue; fileData is the addressed file register contents.
  input wire logic instrValid,
  input wire logic [InstrWidth-1:0] instr,
  input wire logic [DataWidth-1:0] fileData,
  // File register write-back.
  output logic fileWrEn,
  output logic [AddrWidth-1:0] fileWrAddr,
  output logic [DataWidth-1:0] fileWrData,
  // Core state.
  output logic [DataWidth-1:0] acc,
  output logic zeroFlag,
  output logic skipNext,
  output logic done
);

  // The core state. The state machine has two one-hot states: the execute
  // state takes one instruction a cycle, and the skip state spends the cycle
  // of the discarded word. fileWrEn, skipNext and done are one-cycle pulses;
  // the accumulator, the zero flag and the write address hold until changed.
  typedef struct packed {
    exec_state_t fsm;
    logic [DataWidth-1:0] acc;
    logic zero;
    logic wrEn;
    logic [AddrWidth-1:0] wrAddr;
    logic skip;
    logic done;
  } core_state_t;

  // Fields of the offered instruction word, split out once so that every
  // later branch reads the same decode.
  typedef struct packed {
    logic incSkip;
    logic incFile;
    logic orLit;
    logic toFile;
    logic [AddrWidth-1:0] addr;
    logic [DataWidth-1:0] lit;
  } decode_t;

  core_state_t st_r;
  core_state_t st_nxt;
  decode_t dec;
  logic [5:0] opcode;
  logic isInc;

  // Same-cycle arithmetic on the offered operands, and the helper's registered sum.
  logic [DataWidth-1:0] incSum;
  logic incZero;
  logic [DataWidth-1:0] orSum;
  logic orZero;
  logic [DataWidth-1:0] aluSum;

  // Routed results of the offered instruction.
  logic [DataWidth-1:0] accRoute;
  logic zeroRoute;
  logic wrRoute;
  logic skipRoute;
  logic doneRoute;

  // The helper registers fileData plus one on every edge. On the edge after
  // an increment is taken its register holds exactly the value to write
  // back, so the file write data comes straight from it. The skip and the
  // zero flag must be decided in the taking cycle, which is why the core
  // keeps a combinational copy of the same addition. The helper's zero
  // indication comes a cycle too late for either and is left unused.
  incr_alu u_alu (
    .clk(clk),
    .arst_n(arst_n),
    .operand(fileData),
    .sum(aluSum),
    .sumZero()
  );

  assign opcode = instr[OpMsb:OpLsb];

  // Only the three opcodes of this unit are recognised; any other word
  // belongs to another unit and leaves every flag here low.
  always_comb begin
    dec = '0;
    dec.toFile = instr[DestBit];
    dec.addr = instr[AddrMsb:0];
    dec.lit = instr[LitMsb:0];
    case (opcode)
      OpIncSkip: begin
        dec.incSkip = 1'b1;
      end
      OpIncFile: begin
        dec.incFile = 1'b1;
      end
      OpOrLitHi: begin
        dec.orLit = 1'b1;
      end
      default: begin
        // Another unit's opcode: nothing to do here.
        dec.orLit = 1'b0;
      end
    endcase
  end

  assign isInc = dec.incSkip || dec.incFile;

  // The sum is kept to eight bits, so 8'hff steps to 8'h00 and counts as a
  // zero result for both the skip and the zero flag.
  assign incSum = fileData + 8'h01;
  assign incZero = (incSum == 8'h00);
  assign orSum = st_r.acc | dec.lit;
  assign orZero = (orSum == 8'h00);

  // Where the result of the offered instruction goes, worked out apart from
  // the sequencing; the state machine below only decides whether it lands.
  // The accumulator and zero flag hold unless this unit writes them.
  always_comb begin
    accRoute = st_r.acc;
    zeroRoute = st_r.zero;
    wrRoute = 1'b0;
    skipRoute = 1'b0;
    doneRoute = 1'b0;
    if (isInc) begin
      if (dec.toFile) begin
        wrRoute = 1'b1;
      end else begin
        accRoute = incSum;
      end
      if (dec.incFile) begin
        zeroRoute = incZero;
        doneRoute = 1'b1;
      end else if (incZero) begin
        // Completion is reported one cycle later, after the discard.
        skipRoute = 1'b1;
      end else begin
        // The skipping form leaves the status flags alone.
        doneRoute = 1'b1;
      end
    end else if (dec.orLit) begin
      accRoute = orSum;
      zeroRoute = orZero;
      doneRoute = 1'b1;
    end
  end

  // The pulses fall back to zero unless this cycle raises them again. An
  // instruction offered during the skip cycle is the already-fetched word
  // that is discarded, so it is not looked at.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrEn = 1'b0;
    st_nxt.skip = 1'b0;
    st_nxt.done = 1'b0;
    case (st_r.fsm)
      StExec: begin
        if (instrValid) begin
          // The address is latched for every accepted word, so fileWrAddr
          // shows the last decoded address even when nothing is written.
          st_nxt.wrAddr = dec.addr;
          st_nxt.acc = accRoute;
          st_nxt.zero = zeroRoute;
          st_nxt.wrEn = wrRoute;
          st_nxt.skip = skipRoute;
          st_nxt.done = doneRoute;
          if (skipRoute) begin
            st_nxt.fsm = StSkip;
          end
        end
      end
      StSkip: begin
        // The discarded word executes as a no-operation.
        st_nxt.fsm = StExec;
        st_nxt.done = 1'b1;
      end
      default: begin
        // An illegal state code returns to execute rather than hanging.
        st_nxt.fsm = StExec;
      end
    endcase
  end

  // Reset clears the accumulator, the zero flag and every pulse, and parks
  // the state machine ready to take an instruction on the first edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.fsm <= StExec;
      st_r.acc <= AccReset;
      st_r.zero <= ZeroReset;
      st_r.wrEn <= 1'b0;
      st_r.wrAddr <= '0;
      st_r.skip <= 1'b0;
      st_r.done <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from a register: results appear on the edge
  // that takes the word, and done of a skipping increment one edge later
  // still, after the dead cycle.
  assign fileWrEn = st_r.wrEn;
  assign fileWrAddr = st_r.wrAddr;
  assign fileWrData = aluSum;
  assign acc = st_r.acc;
  assign zeroFlag = st_r.zero;
  assign skipNext = st_r.skip;
  assign done = st_r.done;

endmodule // incr_skip_exec
`default_nettype wire

/* File: verification/incr_skip_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module incr_skip_exec_properties
  import incr_exec_pkg::*;
(
  input wire logic clk, arst_n, instrValid,
  input wire logic [InstrWidth-1:0] instr,
  input wire logic [DataWidth-1:0] fileData, fileWrData, acc,
  input wire logic [AddrWidth-1:0] fileWrAddr,
  input wire logic fileWrEn, zeroFlag, skipNext, done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // The second cycle of a skip ignores whatever is offered.
  wire logic tk = instrValid && !skipNext;
  wire logic [5:0] op = instr[13:8];
  wire logic [6:0] adr = instr[6:0];
  wire logic inc = op == OpIncSkip || op == OpIncFile;
  wire logic wrap = fileData == 8'hff;
  a_skip_keeps_flag: assert property (tk && op == OpIncSkip |=> $stable(zeroFlag))
    else $error("zero flag moved");
  a_dest_acc: assert property (tk && inc && !instr[7] |=> acc == $past(fileData) + 8'h01 && !fileWrEn)
    else $error("acc result wrong");
  a_dest_file: assert property (tk && inc && instr[7] |=>
    fileWrEn && fileWrData == $past(fileData) + 8'h01 && fileWrAddr == $past(adr))
    else $error("file write wrong");
  a_skip_on_zero: assert property (tk && op == OpIncSkip && wrap |=> skipNext && !done ##1 done)
    else $error("skip timing wrong");
  a_no_skip_one: assert property (tk && inc && !(op == OpIncSkip && wrap) |=> done && !skipNext)
    else $error("single cycle wrong");
  a_inc_zero_flag: assert property (tk && op == OpIncFile |=> zeroFlag == $past(wrap))
    else $error("zero flag wrong");
  a_or_literal: assert property (tk && op == OpOrLitHi |=>
    done && acc == ($past(acc) | $past(instr[7:0])) && zeroFlag == (acc == 8'h00))
    else $error("or result wrong");
  cover property (tk && inc && wrap);
  cover property (skipNext ##1 done);
  cover property (done && zeroFlag);
endmodule // incr_skip_exec_properties
bind incr_skip_exec incr_skip_exec_properties chk (.*);
`default_nettype wire

/* File: verification/increment_skip_or_literal_exec_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin badCount++; \
  $display("mismatch %0t got %h", $time, a); end end
module increment_skip_or_literal_exec_test;
  import incr_exec_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, instrValid = 1'b0;
  logic [InstrWidth-1:0] instr = 14'h0000;
  logic [DataWidth-1:0] fileData = 8'h00, fileWrData, acc, m = 8'h00;
  logic [AddrWidth-1:0] fileWrAddr;
  logic fileWrEn, zeroFlag, skipNext, done, mz = 1'b0, sk = 1'b0, sawSkip = 1'b0;
  logic [9:0] q[$];
  logic [14:0] wq[$];
  logic [31:0] r;
  logic [5:0] ops [4] = '{OpIncSkip, OpIncFile, OpOrLitHi, 6'h3f};
  int seed = 32'h733a02d9, cyc = 0, badCount = 0, totalChecks = 0;
  incr_skip_exec dut (.*);
  initial forever #5 clk = ~clk;
  task automatic tally_and_finish(input bit hung);
    if (hung) badCount++;
    $display("checks %0d errors %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) tally_and_finish(1'b1);
  end
  // Results show at done; sampling on the falling edge avoids edge races.
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({acc, zeroFlag, sawSkip}, q.pop_front())
    end
    if (fileWrEn === 1'b1) begin
      if (wq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({fileWrAddr, fileWrData}, wq.pop_front())
    end
    sawSkip = skipNext;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    `CHK({acc, zeroFlag, fileWrEn, skipNext, done}, {AccReset, ZeroReset, 3'h0})
    repeat (2000) begin
      @(posedge clk);
      #1 r = $random(seed);
      instrValid = r[31] | r[30];
      fileData = (r[2:0] == 3'h0) ? 8'hff : r[7:0];
      instr = {ops[r[9:8]], r[17:10]};
      if (sk) sk = 1'b0;
      else if (instrValid) begin
        if (instr[13:8] == OpIncSkip || instr[13:8] == OpIncFile) begin
          if (!instr[7]) m = fileData + 8'h01;
          else wq.push_back({instr[6:0], fileData + 8'h01});
          if (instr[13:8] == OpIncFile) mz = fileData == 8'hff;
          else sk = fileData == 8'hff;
          q.push_back({m, mz, sk});
        end else if (instr[13:8] == OpOrLitHi) begin
          m = m | instr[7:0];
          mz = m == 8'h00;
          q.push_back({m, mz, 1'b0});
        end
      end
    end
    @(posedge clk);
    #1 instrValid = 1'b0;
    repeat (4) @(posedge clk);
    `CHK(q.size(), 0)
    `CHK(wq.size(), 0)
    tally_and_finish(1'b0);
  end
endmodule // increment_skip_or_literal_exec_test
`default_nettype wire
